// ### bhr_pkg.sv
// Constants shared by the branch history recorder.
package bhr_pkg;
  // ==========================================================
  // Sizes
  localparam int BHR_ENTRIES = 8;
  localparam int BHR_LIN_W = 48;
  localparam logic [3:0] BHR_DEPTH_RST = 4'h8;
  localparam logic [15:0] BHR_CYC_MAX = 16'hFFFF;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] BHR_OFF_CTL = 12'h000;
  localparam logic [11:0] BHR_OFF_DEPTH = 12'h004;
  localparam logic [11:0] BHR_OFF_STATUS = 12'h008;
  localparam logic [11:0] BHR_OFF_CAP = 12'h00C;
  localparam logic [11:0] BHR_OFF_LER = 12'h020;
  localparam logic [3:0] BHR_REC_PAGE = 4'h1;
  // Word index inside one record slot.
  localparam logic [2:0] BHR_F_SRC_LO = 3'h0;
  localparam logic [2:0] BHR_F_SRC_HI = 3'h1;
  localparam logic [2:0] BHR_F_DST_LO = 3'h2;
  localparam logic [2:0] BHR_F_DST_HI = 3'h3;
  localparam logic [2:0] BHR_F_INFO = 3'h4;
  // ==========================================================
  // Record control fields
  localparam int BHR_CTL_EN = 0;
  localparam int BHR_CTL_KLE = 1;
  localparam int BHR_CTL_ULE = 2;
  localparam int BHR_CTL_STACK = 3;
  localparam int BHR_CTL_FRZ = 4;
  localparam int BHR_CTL_CAT = 16;
  localparam logic [31:0] BHR_CTL_MASK = 32'h007F_001F;
  localparam logic [31:0] BHR_CTL_RST = 32'h0000_0000;
  // ==========================================================
  // Branch kind encodings
  localparam logic [3:0] BHR_KIND_CONDITIONAL_KIND = 4'h0;
  localparam logic [3:0] BHR_KIND_IND_JMP = 4'h1;
  localparam logic [3:0] BHR_KIND_REL_JMP = 4'h2;
  localparam logic [3:0] BHR_KIND_IND_CALL = 4'h3;
  localparam logic [3:0] BHR_KIND_REL_CALL = 4'h4;
  localparam logic [3:0] BHR_KIND_RET = 4'h5;
  localparam logic [2:0] BHR_CAT_OTHER = 3'h6;
  // ==========================================================
  // Record info word layout
  localparam int BHR_INFO_VALID = 31;
  localparam int BHR_INFO_KIND = 16;
  localparam logic [31:0] BHR_INFO_MASK = 32'h800F_FFFF;
  // Source value stored when the start level is filtered out.
  localparam logic [63:0] BHR_SRC_FILLER = 64'h0000_FFFF_FFFF_FFFF;
  // ==========================================================
  // Capability word: permitted depths mask and linear-address flag.
  localparam logic [7:0] BHR_CAP_DEPTHS = 8'hFF;
  localparam int BHR_CAP_LINEAR = 31;
  localparam logic BHR_CAP_LINEAR_VAL = 1'b1;
endpackage : bhr_pkg

// ### bhr_canon.sv
// Sign extension of an address to canonical form.
`timescale 1ns/1ns
module bhr_canon #(
  parameter int LIN_W = 48
) (
  input wire logic [63:0] addr_in,
  output logic [63:0] addr_out
);
  // ==========================================================
  // Upper bits are rebuilt from the top implemented bit.
  assign addr_out = {{(65 - LIN_W){addr_in[LIN_W-1]}}, addr_in[LIN_W-2:0]};
endmodule : bhr_canon

// ### bhr_recorder.sv
// Branch history recorder: record array, filters and APB register file.
//
// What this block does
// - Records are added only while the record enable bit is 1.
// - Suspend input pauses recording; debug transfers clear the enable bit.
// - Depth resets to the entry count; capability field lists permitted depths.
// - Writing depth zeroes every record; the last event record is kept.
// - Access to a record at index not below depth raises a fault.
// - Only enabled kinds record; relative calls to next address do not.
// - Kind codes: 0 conditional_kind, 1..5 jumps/calls/return, 011x reserved, 1xxx other.
// - Debug, VM exit/entry and management interrupts never record.
// - Without stack mode the array is a ring of newest transfers.
// - Stack mode: a return shifts entries up and zeroes the last.
// - Freeze control sets the freeze flag on a pended interrupt; recording stops.
// - Kernel enable covers level zero; user enable covers all higher levels.
// - A level changing transfer records only if its end level is enabled.
// - Filtered start level stores the filler with only the low 48 bits set as source.
// - A capability bit tells whether addresses are linear.
// - Addresses read back are canonical, except the filler source, which is not.
// - Written addresses drop upper bits and sign extend.
// - Cycle counter copies into each new record, then clears and counts.
// - Each record has a cycle valid flag; count limited to 16 bits.
// - Any coarsening of cycle counts stays within ten percent.
// - New record goes to entry zero after older entries shift down.
`timescale 1ns/1ns
module bhr_recorder
  import bhr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ret_valid,
  input wire logic [3:0] ret_kind,
  input wire logic [63:0] ret_src,
  input wire logic [63:0] ret_dst,
  input wire logic [1:0] ret_level_start,
  input wire logic [1:0] ret_level_end,
  input wire logic ret_call_next,
  input wire logic ret_debug,
  input wire logic ret_vm_switch,
  input wire logic ret_mgmt_int,
  input wire logic ret_event,
  input wire logic record_suspend,
  input wire logic perf_monitor_interrupt,
  output logic record_freeze_flag
);
  // ==========================================================
  // State
  logic [31:0] ctl_reg;
  logic [3:0] depth_reg;
  logic [15:0] cyc_reg;
  logic cyc_run_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [63:0] src_mem [BHR_ENTRIES];
  logic [63:0] dst_mem [BHR_ENTRIES];
  logic [31:0] info_mem [BHR_ENTRIES];
  logic [63:0] src_next [BHR_ENTRIES];
  logic [63:0] dst_next [BHR_ENTRIES];
  logic [31:0] info_next [BHR_ENTRIES];
  logic [63:0] ler_src_reg;
  logic [63:0] ler_dst_reg;
  logic [31:0] ler_info_reg;
  // ==========================================================
  // APB decode.
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_acc = access && pwrite;
  wire rec_hit = paddr[11:8] == BHR_REC_PAGE && paddr[4:2] <= BHR_F_INFO;
  wire [2:0] rec_idx = paddr[7:5];
  wire [2:0] rec_fld = paddr[4:2];
  wire rec_fault = rec_hit && {1'b0, rec_idx} >= depth_reg;
  wire ler_hit = paddr[11:5] == BHR_OFF_LER[11:5] && paddr[4:2] <= BHR_F_INFO;
  wire hit_ctl = paddr == BHR_OFF_CTL;
  wire hit_depth = paddr == BHR_OFF_DEPTH;
  wire hit_status = paddr == BHR_OFF_STATUS;
  wire hit_cap = paddr == BHR_OFF_CAP;
  wire mapped = hit_ctl || hit_depth || hit_status || hit_cap || ler_hit || rec_hit;
  wire [3:0] depth_wdata = pwdata[3:0];
  wire depth_ok = pwdata[31:4] == 28'h0 && depth_wdata != 4'h0
    && BHR_CAP_DEPTHS[3'(depth_wdata - 4'h1)] && depth_wdata <= BHR_DEPTH_RST;
  wire depth_wr = wr_acc && hit_depth && depth_ok;
  wire ent_wr = wr_acc && rec_hit && !rec_fault;
  // A software write to the array wins; a transfer retiring in that cycle is dropped.
  wire sw_wr = depth_wr || ent_wr;
  wire setup_err = !mapped || rec_fault || (pwrite && hit_depth && !depth_ok);
  // ==========================================================
  // Filters on the retirement stream.
  wire lvl_end_ok = ret_level_end == 2'h0 ? ctl_reg[BHR_CTL_KLE] : ctl_reg[BHR_CTL_ULE];
  wire lvl_start_ok = ret_level_start == 2'h0 ? ctl_reg[BHR_CTL_KLE] : ctl_reg[BHR_CTL_ULE];
  wire kind_rsvd = ret_kind[3:1] == 3'b011;
  wire [2:0] cat_idx = ret_kind[3] ? BHR_CAT_OTHER : ret_kind[2:0];
  wire cat_en = !kind_rsvd && ctl_reg[BHR_CTL_CAT + int'(cat_idx)];
  wire zero_call = ret_kind == BHR_KIND_REL_CALL && ret_call_next;
  wire excluded = ret_debug || ret_vm_switch || ret_mgmt_int;
  wire take = ret_valid && ctl_reg[BHR_CTL_EN] && !record_suspend && !record_freeze_flag
    && cat_en && !zero_call && !excluded && lvl_end_ok && !sw_wr;
  wire pop = take && ctl_reg[BHR_CTL_STACK] && ret_kind == BHR_KIND_RET;
  wire push = take && !pop;
  wire ler_load = push && ret_event;
  // ==========================================================
  // Canonical forms of retired and written addresses.
  logic [63:0] src_canon;
  logic [63:0] dst_canon;
  logic [63:0] wr_canon;
  wire wr_is_src = rec_fld == BHR_F_SRC_LO || rec_fld == BHR_F_SRC_HI;
  wire [63:0] wr_old = wr_is_src ? src_mem[rec_idx] : dst_mem[rec_idx];
  wire wr_lo = rec_fld == BHR_F_SRC_LO || rec_fld == BHR_F_DST_LO;
  wire [63:0] wr_merge = wr_lo ? {wr_old[63:32], pwdata} : {pwdata, wr_old[31:0]};
  bhr_canon #(.LIN_W(BHR_LIN_W)) u_canon_src (.addr_in(ret_src), .addr_out(src_canon));
  bhr_canon #(.LIN_W(BHR_LIN_W)) u_canon_dst (.addr_in(ret_dst), .addr_out(dst_canon));
  bhr_canon #(.LIN_W(BHR_LIN_W)) u_canon_wr (.addr_in(wr_merge), .addr_out(wr_canon));
  // New record contents.
  wire [63:0] new_src = lvl_start_ok ? src_canon : BHR_SRC_FILLER;
  wire [31:0] new_info = {cyc_run_reg, 11'h0, ret_kind, cyc_reg};
  // ==========================================================
  // Next contents of the record array.
  always_comb begin
    for (int i = 0; i < BHR_ENTRIES; i++) begin
      src_next[i] = src_mem[i];
      dst_next[i] = dst_mem[i];
      info_next[i] = info_mem[i];
      if (depth_wr) begin
        src_next[i] = 64'h0;
        dst_next[i] = 64'h0;
        info_next[i] = 32'h0;
      end else if (ent_wr) begin
        if (i == int'(rec_idx)) begin
          if (rec_fld == BHR_F_INFO) begin
            info_next[i] = pwdata & BHR_INFO_MASK;
          end else if (wr_is_src) begin
            src_next[i] = wr_canon;
          end else begin
            dst_next[i] = wr_canon;
          end
        end
      end else if (push) begin
        if (i == 0) begin
          src_next[i] = new_src;
          dst_next[i] = dst_canon;
          info_next[i] = new_info;
        end else if (4'(i) < depth_reg) begin
          src_next[i] = src_mem[i-1];
          dst_next[i] = dst_mem[i-1];
          info_next[i] = info_mem[i-1];
        end
      end else if (pop) begin
        if (4'(i + 1) < depth_reg) begin
          src_next[i] = src_mem[i+1];
          dst_next[i] = dst_mem[i+1];
          info_next[i] = info_mem[i+1];
        end else if (4'(i + 1) == depth_reg) begin
          src_next[i] = 64'h0;
          dst_next[i] = 64'h0;
          info_next[i] = 32'h0;
        end
      end
    end
  end
  // Record array storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BHR_ENTRIES; i++) begin
        src_mem[i] <= 64'h0;
        dst_mem[i] <= 64'h0;
        info_mem[i] <= 32'h0;
      end
    end else begin
      src_mem <= src_next;
      dst_mem <= dst_next;
      info_mem <= info_next;
    end
  end
  // ==========================================================
  // Last event record: the branch that preceded an exception or interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ler_src_reg <= 64'h0;
      ler_dst_reg <= 64'h0;
      ler_info_reg <= 32'h0;
    end else if (ler_load) begin
      ler_src_reg <= src_mem[0];
      ler_dst_reg <= dst_mem[0];
      ler_info_reg <= info_mem[0];
    end
  end
  // ==========================================================
  // Control, depth and freeze flag; debug clear beats a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= BHR_CTL_RST;
      depth_reg <= BHR_DEPTH_RST;
      record_freeze_flag <= 1'b0;
    end else begin
      if (ret_valid && ret_debug) begin
        ctl_reg[BHR_CTL_EN] <= 1'b0;
      end else if (wr_acc && hit_ctl) begin
        ctl_reg <= pwdata & BHR_CTL_MASK;
      end
      if (depth_wr) begin
        depth_reg <= depth_wdata;
      end
      if (perf_monitor_interrupt && ctl_reg[BHR_CTL_FRZ]) begin
        record_freeze_flag <= 1'b1;
      end else if (wr_acc && hit_status && pwdata[0]) begin
        record_freeze_flag <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Saturating cycle counter; cleared on every new record.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= 16'h0;
      cyc_run_reg <= 1'b0;
    end else if (push) begin
      cyc_reg <= 16'h0;
      cyc_run_reg <= 1'b1;
    end else if (cyc_reg != BHR_CYC_MAX) begin
      cyc_reg <= cyc_reg + 16'h1;
    end
  end
  // ==========================================================
  // Read selection.
  wire [63:0] sel_src = ler_hit ? ler_src_reg : src_mem[rec_idx];
  wire [63:0] sel_dst = ler_hit ? ler_dst_reg : dst_mem[rec_idx];
  wire [31:0] sel_info = ler_hit ? ler_info_reg : info_mem[rec_idx];
  wire [31:0] rec_word = rec_fld == BHR_F_SRC_LO ? sel_src[31:0]
    : rec_fld == BHR_F_SRC_HI ? sel_src[63:32]
    : rec_fld == BHR_F_DST_LO ? sel_dst[31:0]
    : rec_fld == BHR_F_DST_HI ? sel_dst[63:32] : sel_info;
  wire [31:0] cap_word = {BHR_CAP_LINEAR_VAL, 23'h0, BHR_CAP_DEPTHS};
  wire [31:0] rd_mux = hit_ctl ? ctl_reg
    : hit_depth ? {28'h0, depth_reg}
    : hit_status ? {31'h0, record_freeze_flag}
    : hit_cap ? cap_word
    : (ler_hit || (rec_hit && !rec_fault)) ? rec_word : 32'h0;
  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0 : rd_mux;
      err_reg <= setup_err;
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access && err_reg;
  // ==========================================================
  // Checks.
  chk_rec_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && !ctl_reg[BHR_CTL_EN] && !sw_wr
    |=> $stable(src_mem[0]) && $stable(info_mem[0]))
    else $error("record taken while disabled");
  chk_debug_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && ret_debug |=> !ctl_reg[BHR_CTL_EN] && $stable(src_mem[0]))
    else $error("debug transfer did not clear enable");
  chk_depth_zero: assert property (@(posedge pclk) disable iff (!presetn)
    depth_wr |=> src_mem[0] == 64'h0 && info_mem[0] == 32'h0
    && $stable(ler_info_reg)) else $error("depth write did not clear records");
  chk_range_fault: assert property (@(posedge pclk) disable iff (!presetn)
    access && rec_hit && {1'b0, rec_idx} >= depth_reg |-> pslverr)
    else $error("out of depth access not faulted");
  chk_excluded_xfer: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && excluded |-> !push && !pop) else $error("excluded transfer recorded");
  chk_push_shift: assert property (@(posedge pclk) disable iff (!presetn)
    push && !depth_wr && !ent_wr && depth_reg > 4'h1 |=> src_mem[0] == $past(new_src)
    && src_mem[1] == $past(src_mem[0])) else $error("push did not shift records");
  chk_stack_pop: assert property (@(posedge pclk) disable iff (!presetn)
    pop && !depth_wr && !ent_wr |=> info_mem[3'($past(depth_reg) - 4'h1)] == 32'h0
    && src_mem[0] == $past(src_mem[1], 1)) else $error("return did not pop");
  chk_freeze_set: assert property (@(posedge pclk) disable iff (!presetn)
    perf_monitor_interrupt && ctl_reg[BHR_CTL_FRZ] |=> record_freeze_flag ##1 !push)
    else $error("freeze flag not set or recording continued");
  chk_filler_src: assert property (@(posedge pclk) disable iff (!presetn)
    push && !depth_wr && !ent_wr && !lvl_start_ok |=> src_mem[0] == BHR_SRC_FILLER)
    else $error("filtered source not replaced by filler");
  chk_cyc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    cyc_reg == BHR_CYC_MAX && !push |=> cyc_reg == BHR_CYC_MAX)
    else $error("cycle counter wrapped");
  chk_cyc_copy: assert property (@(posedge pclk) disable iff (!presetn)
    push && !depth_wr && !ent_wr |=> info_mem[0][15:0] == $past(cyc_reg) && cyc_reg == 16'h0)
    else $error("cycle count not copied and cleared");
  // Entry zero must hold still whenever the kind filter or the next-address call rule refuses the retiring transfer.
  chk_kind_filter: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && (!cat_en || zero_call) && !sw_wr
    |=> $stable(src_mem[0]) && $stable(info_mem[0]))
    else $error("refused kind was recorded");
  chk_level_filter: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && !lvl_end_ok && !sw_wr
    |=> $stable(src_mem[0]) && $stable(dst_mem[0]))
    else $error("filtered level was recorded");
  chk_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ret_valid && record_suspend && !sw_wr
    |=> $stable(src_mem[0]) && $stable(info_mem[0]))
    else $error("suspended transfer was recorded");
  chk_freeze_stop: assert property (@(posedge pclk) disable iff (!presetn)
    record_freeze_flag && !sw_wr
    |=> $stable(src_mem[0]) && $stable(ler_src_reg))
    else $error("frozen recorder changed a record");
  // The freeze flag clears on a write of one unless a new interrupt sets it again.
  chk_freeze_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_status && pwdata[0] && !(perf_monitor_interrupt && ctl_reg[BHR_CTL_FRZ])
    |=> !record_freeze_flag)
    else $error("freeze flag not cleared");
  // The destination in entry zero stays canonical, whether retired or written.
  chk_dst_canon: assert property (@(posedge pclk) disable iff (!presetn)
    &dst_mem[0][63:BHR_LIN_W-1] || ~|dst_mem[0][63:BHR_LIN_W-1])
    else $error("destination not canonical");
  // A new record carries the kind and a valid flag once a previous record exists.
  chk_info_fields: assert property (@(posedge pclk) disable iff (!presetn)
    push && cyc_run_reg
    |=> info_mem[0][BHR_INFO_VALID] && info_mem[0][BHR_INFO_KIND+:4] == $past(ret_kind))
    else $error("record info word wrong");
  // The last event record changes only when a recorded event loads it.
  chk_ler_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !ler_load |=> $stable(ler_src_reg) && $stable(ler_info_reg))
    else $error("last event record changed");
  // Depth never leaves the range that the capability word allows.
  chk_depth_range: assert property (@(posedge pclk) disable iff (!presetn)
    depth_reg != 4'h0 && depth_reg <= BHR_DEPTH_RST)
    else $error("depth out of range");
  cov_depth_write: cover property (@(posedge pclk) disable iff (!presetn) depth_wr);
  cov_push: cover property (@(posedge pclk) disable iff (!presetn) push ##1 push);
  cov_pop: cover property (@(posedge pclk) disable iff (!presetn) push ##[1:4] pop);
  cov_freeze: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(record_freeze_flag));
  cov_fault: cover property (@(posedge pclk) disable iff (!presetn) pslverr && rec_hit);
endmodule : bhr_recorder

// ### bhr_core_model.sv
// Model of the core retirement stream that feeds transfers to the recorder.
`timescale 1ns/1ns
module bhr_core_model (
  input wire logic pclk,
  output logic ret_valid,
  output logic [3:0] ret_kind,
  output logic [63:0] ret_src,
  output logic [63:0] ret_dst,
  output logic [1:0] ret_level_start,
  output logic [1:0] ret_level_end,
  output logic ret_call_next,
  output logic ret_debug,
  output logic ret_vm_switch,
  output logic ret_mgmt_int,
  output logic ret_event
);
  // ==========================================================
  // Idle stream
  // Nothing retires before the bench asks for it.
  initial begin
    ret_valid = 1'b0;
    {ret_kind, ret_src, ret_dst, ret_level_start, ret_level_end} = '0;
    {ret_call_next, ret_debug, ret_vm_switch, ret_mgmt_int, ret_event} = 5'h00;
  end

  // Retires one transfer for one cycle, then scrambles the idle fields.
  task automatic retire(input logic [3:0] k, input logic [31:0] s, input logic [1:0] ls,
                        input logic [1:0] le, input logic [4:0] f);
    @(posedge pclk);
    ret_valid <= 1'b1;
    ret_kind <= k;
    ret_src <= {32'h0000_0000, s};
    ret_dst <= {32'h0000_0000, s + 32'h0000_1000};
    ret_level_start <= ls;
    ret_level_end <= le;
    {ret_call_next, ret_debug, ret_vm_switch, ret_mgmt_int, ret_event} <= f;
    @(posedge pclk);
    ret_valid <= 1'b0;
    ret_kind <= ~k;
    ret_src <= ~ret_src;
    ret_dst <= ~ret_dst;
    {ret_call_next, ret_debug, ret_vm_switch, ret_mgmt_int, ret_event} <= ~f;
  endtask : retire
endmodule : bhr_core_model

// ### branch_history_recorder_tb.sv
// Self-checking bench for the branch history recorder.
`timescale 1ns/1ns
module branch_history_recorder_tb
  import bhr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, c0, c1;
  logic record_suspend, perf_monitor_interrupt, record_freeze_flag;
  logic ret_valid, ret_call_next, ret_debug, ret_vm_switch, ret_mgmt_int, ret_event;
  logic [3:0] ret_kind;
  logic [63:0] ret_src, ret_dst;
  logic [1:0] ret_level_start, ret_level_end;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [3:0] kinds [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
  logic [3:0] fk [5] = '{4'h0, 4'h4, 4'h8, 4'h8, 4'h8};
  logic [4:0] ff [5] = '{5'h00, 5'h10, 5'h04, 5'h02, 5'h08};

  bhr_recorder i_bhr_recorder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ret_valid, .ret_kind, .ret_src, .ret_dst, .ret_level_start,
    .ret_level_end, .ret_call_next, .ret_debug, .ret_vm_switch, .ret_mgmt_int, .ret_event,
    .record_suspend, .perf_monitor_interrupt, .record_freeze_flag);
  bhr_core_model i_bhr_core_model (.pclk, .ret_valid, .ret_kind, .ret_src, .ret_dst,
    .ret_level_start, .ret_level_end, .ret_call_next, .ret_debug, .ret_vm_switch,
    .ret_mgmt_int, .ret_event);

  // ==========================================================
  // Clock and hang guard
  // The clock toggles every half period; the guard ends a stuck run.
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================
  // Bus and check tasks
  // One APB transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  // Reads a register, compares masked data and checks that no error came back.
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdv & m);
    chk(nm, 32'h0000_0000, {31'h0, err});
  endtask : rd

  // Byte address of one word of one record slot.
  function automatic logic [11:0] rec(input int idx, input logic [2:0] w);
    return 12'h100 + 12'(idx) * 12'h020 + 12'(w) * 12'h004;
  endfunction : rec

  task automatic rt(input logic [3:0] k, input logic [31:0] s, input logic [1:0] ls = 2'h0,
                    input logic [1:0] le = 2'h0, input logic [4:0] f = 5'h00);
    i_bhr_core_model.retire(k, s, ls, le, f);
  endtask : rt

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask : done

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Test sequence
  initial begin
    {presetn, psel, penable, pwrite, record_suspend, perf_monitor_interrupt} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("control", BHR_OFF_CTL, 32'h0000_0000);
    rd("depth", BHR_OFF_DEPTH, 32'h0000_0008);
    rd("capability", BHR_OFF_CAP, 32'h8000_00FF);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    rt(4'h0, 32'h0000_1000);
    rd("disabled entry", rec(0, 0), 32'h0000_0000);
    done("reset");
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0007);
    for (int i = 0; i < 7; i++) rt(kinds[i], 32'h0000_0100 + i);
    for (int i = 0; i < 7; i++) begin
      rd("kind", rec(i, 4), {12'h000, kinds[6-i], 16'h0000}, 32'h000F_0000);
      rd("source", rec(i, 0), 32'h0000_0106 - i);
    end
    rt(4'h2, 32'h0000_0200);
    rt(4'h2, 32'h0000_0201);
    rd("ring oldest", rec(7, 0), 32'h0000_0101);
    rt(4'h6, 32'h0000_0202);
    rd("reserved kind", rec(0, 0), 32'h0000_0201);
    done("ring");
    apb(1'b1, BHR_OFF_CTL, 32'h007E_0007);
    for (int i = 0; i < 5; i++) begin
      rt(fk[i], 32'h0000_0300 + i, 2'h0, 2'h0, ff[i]);
      rd("filtered", rec(0, 0), 32'h0000_0201);
    end
    rd("debug clears enable", BHR_OFF_CTL, 32'h007E_0006);
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0007);
    @(posedge pclk);
    record_suspend <= 1'b1;
    rt(4'h1, 32'h0000_0310);
    record_suspend <= 1'b0;
    rd("suspended", rec(0, 0), 32'h0000_0201);
    rd("enable kept", BHR_OFF_CTL, 32'h007F_0007);
    done("filters");
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0003);
    rt(4'h0, 32'h0000_0400, 2'h3, 2'h3);
    rt(4'h0, 32'h0000_0401, 2'h0, 2'h3);
    rd("user filtered", rec(0, 0), 32'h0000_0201);
    rt(4'h8, 32'h0000_0500, 2'h3, 2'h0);
    rd("filler lo", rec(0, 0), 32'hFFFF_FFFF);
    rd("filler hi", rec(0, 1), 32'h0000_FFFF);
    rd("destination", rec(0, 2), 32'h0000_1500);
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0005);
    rt(4'h0, 32'h0000_0403, 2'h2, 2'h2);
    rd("user level", rec(0, 0), 32'h0000_0403);
    apb(1'b1, rec(0, 1), 32'h1234_8000);
    rd("canonical up", rec(0, 1), 32'hFFFF_8000);
    apb(1'b1, rec(0, 3), 32'hFFFF_7FFF);
    rd("canonical down", rec(0, 3), 32'h0000_7FFF);
    done("levels");
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0007);
    rt(4'h0, 32'h0000_0600);
    repeat (10) @(posedge pclk);
    rt(4'h0, 32'h0000_0601);
    repeat (30) @(posedge pclk);
    rt(4'h0, 32'h0000_0602);
    apb(1'b0, rec(0, 4), 32'h0000_0000);
    c0 = rdv;
    apb(1'b0, rec(1, 4), 32'h0000_0000);
    c1 = rdv;
    chk("cycle valid", 32'h0000_0003, {30'h0, c0[31], c1[31]});
    chk("cycle gap", 32'h0000_0014, {16'h0, c0[15:0] - c1[15:0]});
    repeat (70000) @(posedge pclk);
    rt(4'h0, 32'h0000_0603);
    rd("saturated", rec(0, 4), 32'h8000_FFFF, 32'h8000_FFFF);
    rt(4'h0, 32'h0000_0604, 2'h0, 2'h0, 5'h01);
    rd("event record", BHR_OFF_LER, 32'h0000_0603);
    done("cycles");
    apb(1'b1, BHR_OFF_DEPTH, 32'h0000_0004);
    rd("cleared src", rec(0, 0), 32'h0000_0000);
    rd("cleared info", rec(3, 4), 32'h0000_0000);
    apb(1'b0, rec(4, 0), 32'h0000_0000);
    chk("read beyond depth", 32'h0000_0001, {31'h0, err});
    apb(1'b1, rec(7, 2), 32'h0000_0005);
    chk("write beyond depth", 32'h0000_0001, {31'h0, err});
    apb(1'b1, BHR_OFF_DEPTH, 32'h0000_0009);
    chk("bad depth", 32'h0000_0001, {31'h0, err});
    rd("depth kept", BHR_OFF_DEPTH, 32'h0000_0004);
    rd("event kept", BHR_OFF_LER, 32'h0000_0603);
    done("depth");
    apb(1'b1, BHR_OFF_CTL, 32'h0038_000B);
    for (int i = 1; i < 5; i++) rt(4'h4, 32'h0000_0700 + i);
    rt(4'h5, 32'h0000_07FF);
    rd("pop top", rec(0, 0), 32'h0000_0703);
    rd("pop tail", rec(3, 0), 32'h0000_0000);
    done("stack");
    apb(1'b1, BHR_OFF_CTL, 32'h007F_0017);
    @(posedge pclk);
    perf_monitor_interrupt <= 1'b1;
    @(posedge pclk);
    perf_monitor_interrupt <= 1'b0;
    rd("freeze status", BHR_OFF_STATUS, 32'h0000_0001);
    chk("freeze flag", 32'h0000_0001, {31'h0, record_freeze_flag});
    rt(4'h0, 32'h0000_0800);
    rd("frozen", rec(0, 0), 32'h0000_0703);
    apb(1'b1, BHR_OFF_STATUS, 32'h0000_0001);
    rt(4'h0, 32'h0000_0801);
    rd("thawed", rec(0, 0), 32'h0000_0801);
    done("freeze");
    print_verdict();
  end
endmodule : branch_history_recorder_tb
